//--- bench/serial_peer.sv
`timescale 1ns/100ps
// Remote clock source for the synchronous slave mode
module serial_peer (
    // Clock and pin drive
    input  wire logic clk,
    output logic      sck,
    output logic      sck_en
);
    // Clock bursts; the line stands still at idle level between them
    // below fosc/4
    task automatic burst(input int n, input int half);
        sck_en = 1'b1;
        repeat (2 * n) begin
            repeat (half) @(posedge clk);
            #2 sck = ~sck;
        end
    endtask
    // Idle and undriven at start
    initial begin
        sck = 1'b0;
        sck_en = 1'b0;
    end
endmodule

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench
    import usart_clkgen_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  dh;
    logic [7:0]  dl;
    logic        dhw, dlw, msh, msl, dss, pol, pha, dir, txe, rxe;
    logic        pin_out, oe_n, txs, rxs, pin_q, tx_lvl;
    logic [11:0] bdiv;
    logic [4:0]  cmode;
    wire         psck, pen, sck_in;
    int          cyc, rx_gap, tx_gap, pin_gap, lat, rx_cnt, rx_at, tx_at;
    int          pin_at, fail_count, samples_checked, d, n;

    // Clock of 25 ns
    always #12.5 clk = ~clk;
    // Wire level; an undriven pin shows a slow pattern, below fosc/4
    assign sck_in = (oe_n === 1'b0) ? pin_out : pen ? psck : cyc[2];

    usart_clkgen i_usart_clkgen (
        .clk(clk), .rst(rst), .baud_divisor_high(dh),
        .baud_divisor_high_wr(dhw), .baud_divisor_low(dl),
        .baud_divisor_low_wr(dlw), .mode_select_high(msh),
        .mode_select_low(msl), .double_speed_select(dss),
        .clock_polarity_bit(pol), .clock_phase_bit(pha),
        .serial_clock_pin_direction(dir), .transmitter_enable_bit(txe),
        .receiver_enable_bit(rxe), .serial_clock_pin_in(sck_in),
        .serial_clock_pin_out(pin_out), .serial_clock_pin_oe_n(oe_n),
        .tx_shift(txs), .rx_sample(rxs), .baud_divisor(bdiv),
        .clock_mode(cmode));
    serial_peer i_serial_peer (.clk(clk), .sck(psck), .sck_en(pen));

    // Spacing of strobes and pin edges; also cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pin_q <= sck_in;
        if (rxs === 1'b1) begin
            rx_gap <= cyc - rx_at;
            rx_at <= cyc;
            rx_cnt <= rx_cnt + 1;
        end
        if (txs === 1'b1) begin
            tx_gap <= cyc - tx_at;
            tx_at <= cyc;
            tx_lvl <= sck_in;
            lat <= cyc - pin_at;
        end
        if (sck_in !== pin_q) begin
            pin_gap <= cyc - pin_at;
            pin_at <= cyc;
        end
        if (cyc > 8000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // Mode and enables, divisor written whole, then settle
    task automatic setup(input logic [1:0] ms, input logic dr,
                         input logic t, input logic r, input int dv);
        @(posedge clk) #2;
        txe = 1'b0;
        rxe = 1'b0;
        @(posedge clk) #2;
        {msh, msl} = ms;
        dir = dr;
        {dh, dl} = dv[11:0];
        dhw = 1'b1;
        dlw = 1'b1;
        @(posedge clk) #2;
        dhw = 1'b0;
        dlw = 1'b0;
        // Engines start only once the new rate is in place
        txe = t;
        rxe = r;
        // Long enough for two bit periods at divisor 6
        repeat (300) @(posedge clk);
        #2;
        chk("divisor", dv, bdiv);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        void'($urandom(86));
        {dh, dl, dhw, dlw, msh, msl, dss, pol, pha, dir, txe, rxe} = '0;
        repeat (5) @(posedge clk);
        chk("divisor", 12'h000, bdiv);
        chk("mode", MODE_HALT, cmode);
        #2 rst = 1'b0;
        // Halves written apart keep each other; top value
        @(posedge clk) #2;
        {dl, dlw, dh} = {8'hff, 1'b1, 4'hf};
        @(posedge clk) #2;
        {dlw, dhw} = 2'b01;
        @(posedge clk) #2;
        dhw = 1'b0;
        @(posedge clk) #2;
        chk("divisor", 12'hfff, bdiv);
        for (int ds = 0; ds < 2; ds++) begin
            d = $urandom_range(6, 0);
            dss = ds[0];
            setup(2'h0, 1'b0, 1'b1, 1'b1, d);
            chk("rx gap", d + 1, rx_gap);
            chk("tx gap", (ds ? 8 : 16) * (d + 1), tx_gap);
            chk("mode", MODE_ASYNC, cmode);
        end
        // Master with double speed wrongly set: rate must not move
        pol = $urandom_range(1, 0);
        d = $urandom_range(6, 0);
        setup(2'h1, 1'b1, 1'b1, 1'b1, d);
        chk("pin gap", d + 1, pin_gap);
        chk("tx gap", 2 * (d + 1), tx_gap);
        chk("oe_n", 1'b0, oe_n);
        chk("tx level", !pol, tx_lvl);
        chk("mode", MODE_SMASTER, cmode);
        // Slave: peer clock, divisor must not matter
        {dss, pol} = 2'b00;
        setup(2'h1, 1'b0, 1'b1, 1'b1, 5);
        i_serial_peer.burst(20, 3);
        chk("oe_n", 1'b1, oe_n);
        chk("latency", 3, lat);
        chk("tx gap", 6, tx_gap);
        chk("mode", MODE_SSLAVE, cmode);
        setup(2'h3, 1'b1, 1'b0, 1'b1, 0);
        n = rx_cnt;
        repeat (60) @(posedge clk);
        chk("rx count", n, rx_cnt);
        // both phases, divisor zero at enable
        for (int p = 0; p < 2; p++) begin
            pha = p[0];
            setup(2'h3, 1'b1, 1'b1, 1'b1, 0);
            chk("tx level", p ? !pol : pol, tx_lvl);
            chk("rx gap", 2, rx_gap);
            chk("mode", MODE_SPIM, cmode);
        end
        // Pin as input in SPI, and the reserved code: no strobes
        for (int i = 0; i < 2; i++) begin
            setup(i ? 2'h2 : 2'h3, i[0], 1'b1, 1'b1, 0);
            n = rx_cnt;
            repeat (60) @(posedge clk);
            chk("rx count", n, rx_cnt);
            chk("mode", MODE_HALT, cmode);
        end
        complete_run();
    end
endmodule

//--- inc/usart_clkgen_consts.svh
`ifndef USART_CLKGEN_CONSTS_SVH
`define USART_CLKGEN_CONSTS_SVH

// Baud divisor reset value and byte split
`define UCG_DIV_RST      12'h000
`define UCG_DIV_LOW_W    8
// Oversampling ticks per bit in asynchronous operation
`define UCG_OS_NORMAL    5'h10
`define UCG_OS_DOUBLE    5'h08
// Mode select encodings {mode_select_high, mode_select_low}
`define UCG_MSEL_ASYNC   2'h0
`define UCG_MSEL_SYNC    2'h1
`define UCG_MSEL_MSPI    2'h3
// Input synchroniser depth on the serial clock pin
`define UCG_SYNC_STAGES  2

`endif

//--- inc/usart_clkgen_pkg.sv
package usart_clkgen_pkg;

    // Clocking mode, one-hot
    typedef enum logic [4:0] {
        MODE_ASYNC   = 5'b00001,
        MODE_SMASTER = 5'b00010,
        MODE_SSLAVE  = 5'b00100,
        MODE_SPIM    = 5'b01000,
        MODE_HALT    = 5'b10000
    } clk_mode_e;

endpackage

//--- src/usart_clkgen.sv
`timescale 1ns/100ps
`include "usart_clkgen_consts.svh"
module usart_clkgen
    import usart_clkgen_pkg::*;
#(
    parameter int DIV_W = 12
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Divisor writes
    input  wire logic [DIV_W-9:0] baud_divisor_high,
    input  wire logic             baud_divisor_high_wr,
    input  wire logic [7:0]       baud_divisor_low,
    input  wire logic             baud_divisor_low_wr,
    // Mode configuration
    input  wire logic             mode_select_high,
    input  wire logic             mode_select_low,
    input  wire logic             double_speed_select,
    input  wire logic             clock_polarity_bit,
    input  wire logic             clock_phase_bit,
    input  wire logic             serial_clock_pin_direction,
    input  wire logic             transmitter_enable_bit,
    input  wire logic             receiver_enable_bit,
    // Serial clock pin
    input  wire logic             serial_clock_pin_in,
    output logic                  serial_clock_pin_out,
    output logic                  serial_clock_pin_oe_n,
    // Timing strobes to the frame engines
    output logic                  tx_shift,
    output logic                  rx_sample,
    // Status
    output logic [DIV_W-1:0]      baud_divisor,
    output logic [4:0]            clock_mode
);

    // Whole divisor needs 9 to 16 bits, so the high half has 1 to 8; refused at elaboration
    if (DIV_W < 9 || DIV_W > 16) begin : g_div_w_check
        $error("usart_clkgen: DIV_W must be 9..16");
    end

    localparam logic [4:0] OS_N = `UCG_OS_NORMAL;
    localparam logic [4:0] OS_D = `UCG_OS_DOUBLE;

    clk_mode_e              mode_ff, nxt_mode;
    logic [DIV_W-1:0]       div_ff, nxt_div;
    logic [DIV_W-1:0]       cnt_ff, nxt_cnt;
    logic [3:0]             os_ff, nxt_os;
    logic [`UCG_SYNC_STAGES:0] sync_ff, nxt_sync;
    logic                   xck_ff, nxt_xck;
    logic                   oe_n_ff, nxt_oe_n;
    logic                   txs_ff, nxt_txs;
    logic                   rxs_ff, nxt_rxs;
    logic                   div_wr, run, tick, os_last;
    logic                   ext_rise, ext_fall, edge_evt, lead_evt;
    logic                   shift_on_lead, rx_ok;

    // Mode decode and divisor register
    always_comb begin
        nxt_mode = MODE_HALT;
        unique case ({mode_select_high, mode_select_low})
            `UCG_MSEL_ASYNC: nxt_mode = MODE_ASYNC;
            `UCG_MSEL_SYNC:  nxt_mode = serial_clock_pin_direction ?
                                        MODE_SMASTER : MODE_SSLAVE;
            // SPI needs the pin as output
            `UCG_MSEL_MSPI:  nxt_mode = serial_clock_pin_direction ?
                                        MODE_SPIM : MODE_HALT;
            default:         nxt_mode = MODE_HALT;
        endcase
        nxt_div = div_ff;
        if (baud_divisor_high_wr) begin
            nxt_div[DIV_W-1:8] = baud_divisor_high;
        end
        if (baud_divisor_low_wr) begin
            nxt_div[7:0] = baud_divisor_low;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_ff <= MODE_HALT;
            div_ff  <= DIV_W'(`UCG_DIV_RST);
        end else begin
            mode_ff <= nxt_mode;
            div_ff  <= nxt_div;
        end
    end

    assign div_wr = baud_divisor_high_wr | baud_divisor_low_wr;

    // Generator runs only while a frame engine is enabled
    assign run = (mode_ff != MODE_HALT) && (mode_ff != MODE_SSLAVE) &&
                 (transmitter_enable_bit | receiver_enable_bit);
    // counter parked at divisor so zero ticks at once
    assign tick = run && !div_wr && (cnt_ff == '0);
    // 8 samples per bit in double speed
    assign os_last = double_speed_select ? (os_ff == 4'(OS_D - 5'h01))
                                         : (os_ff == 4'(OS_N - 5'h01));

    // the last synchroniser stage feeds the edge detector
    assign ext_rise = sync_ff[`UCG_SYNC_STAGES-1] & ~sync_ff[`UCG_SYNC_STAGES];
    assign ext_fall = ~sync_ff[`UCG_SYNC_STAGES-1] & sync_ff[`UCG_SYNC_STAGES];

    // Edge selection for synchronous modes
    always_comb begin
        edge_evt = 1'b0;
        lead_evt = 1'b0;
        // external edges used only as slave
        if (mode_ff == MODE_SSLAVE) begin
            edge_evt = ext_rise | ext_fall;
            lead_evt = clock_polarity_bit ? ext_fall : ext_rise;
        end else if (mode_ff == MODE_SMASTER || mode_ff == MODE_SPIM) begin
            edge_evt = tick;
            lead_evt = tick && (xck_ff == clock_polarity_bit);
        end
        // phase zero samples the leading edge
        shift_on_lead = (mode_ff == MODE_SPIM) ? clock_phase_bit : 1'b1;
        rx_ok = receiver_enable_bit &&
                (mode_ff != MODE_SPIM || transmitter_enable_bit);
    end

    // Baud counter, oversampler, pin clock and strobes
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_os   = os_ff;
        nxt_sync = {sync_ff[`UCG_SYNC_STAGES-1:0], serial_clock_pin_in};
        nxt_xck  = xck_ff;
        nxt_txs  = 1'b0;
        nxt_rxs  = 1'b0;
        // reload on write, idle or zero
        if (div_wr || !run || cnt_ff == '0) begin
            nxt_cnt = nxt_div;
        end else begin
            nxt_cnt = cnt_ff - DIV_W'(1);
        end
        // drive the pin only as master
        nxt_oe_n = !(mode_ff == MODE_SMASTER || mode_ff == MODE_SPIM);
        unique case (mode_ff)
            MODE_ASYNC: begin
                // bit is 16 or 8 baud ticks
                if (tick) begin
                    nxt_os  = os_last ? 4'h0 : os_ff + 4'h1;
                    nxt_txs = transmitter_enable_bit && os_last;
                    nxt_rxs = rx_ok;
                end
                nxt_xck = clock_polarity_bit;
            end
            MODE_SMASTER, MODE_SPIM, MODE_SSLAVE: begin
                nxt_os = 4'h0;
                // toggle per tick halves the rate
                if (mode_ff != MODE_SSLAVE) begin
                    nxt_xck = run ? xck_ff ^ tick : clock_polarity_bit;
                end
                // shift and sample on opposite edges
                nxt_txs = transmitter_enable_bit && edge_evt &&
                          (lead_evt == shift_on_lead);
                nxt_rxs = rx_ok && edge_evt && (lead_evt != shift_on_lead);
            end
            MODE_HALT: begin
                nxt_os  = 4'h0;
                nxt_xck = clock_polarity_bit;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= DIV_W'(`UCG_DIV_RST);
            os_ff   <= 4'h0;
            sync_ff <= '0;
            xck_ff  <= 1'b0;
            oe_n_ff <= 1'b1;
            txs_ff  <= 1'b0;
            rxs_ff  <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            os_ff   <= nxt_os;
            sync_ff <= nxt_sync;
            xck_ff  <= nxt_xck;
            oe_n_ff <= nxt_oe_n;
            txs_ff  <= nxt_txs;
            rxs_ff  <= nxt_rxs;
        end
    end

    // Outputs straight from flip-flops
    assign serial_clock_pin_out  = xck_ff;
    assign serial_clock_pin_oe_n = oe_n_ff;
    assign tx_shift              = txs_ff;
    assign rx_sample             = rxs_ff;
    assign baud_divisor          = div_ff;
    assign clock_mode            = mode_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_pin_rise;
        (mode_ff == MODE_SSLAVE) && $rose(serial_clock_pin_in);
    endsequence
    sequence s_slave_hold;
        (mode_ff == MODE_SSLAVE)[*2];
    endsequence

    AST_DIV_RELOAD: assert property (
        div_wr |=> cnt_ff == div_ff)
        else $error("counter not reloaded on divisor write");
    AST_TICK_RELOAD: assert property (
        tick && !div_wr |=> cnt_ff == $past(div_ff))
        else $error("counter not reloaded after tick");
    AST_SLAVE_DELAY: assert property (
        s_pin_rise ##0 s_slave_hold |-> ##1 ext_rise)
        else $error("external edge not seen two cycles later");
    AST_PIN_DIR: assert property (
        mode_ff == MODE_SSLAVE |=> serial_clock_pin_oe_n)
        else $error("slave drives the clock pin");
    AST_SPI_DRIVE: assert property (
        mode_ff == MODE_SPIM |=> !serial_clock_pin_oe_n)
        else $error("SPI master not driving the clock pin");
    AST_EXT_SLAVE: assert property (
        mode_ff != MODE_SSLAVE && !tick |=> !tx_shift && !rx_sample)
        else $error("strobe without a baud tick outside slave mode");
    AST_OPP_EDGE: assert property (
        mode_ff != MODE_ASYNC |-> !(nxt_txs && nxt_rxs))
        else $error("shift and sample on the same edge");
    AST_SPI_RX: assert property (
        mode_ff == MODE_SPIM && !transmitter_enable_bit |=> !rx_sample)
        else $error("SPI receiver ran without transmitter");
    AST_DS_BIT: assert property (
        mode_ff == MODE_ASYNC && double_speed_select && tick && os_last
        |-> os_ff == 4'h7)
        else $error("double speed bit length not 8 samples");
    AST_MASTER_TOGGLE: assert property (
        mode_ff == MODE_SMASTER && $past(mode_ff) == MODE_SMASTER &&
        $changed(xck_ff) && $past(run) |-> $past(tick))
        else $error("master clock toggled without a tick");

endmodule
